// ==== verilog/aes_regs_pkg.sv ====
// Register map, field layout and codes of the cipher register block
package aes_regs_pkg;
   localparam logic [31:0] IMR_ADDR = 32'h4000_0018;
   localparam logic [31:0] ISR_ADDR = 32'h4000_001C;
   localparam logic [31:0] KEY_BASE = 32'h4000_0020;
   localparam logic [31:0] IN_BASE = 32'h4000_0040;
   localparam logic [31:0] OUT_BASE = 32'h4000_0050;
   localparam logic [31:0] IV_BASE = 32'h4000_0060;
   localparam int KEY_WORDS = 8;
   localparam int BLK_WORDS = 4;
   localparam int IDX_W = 3;
   localparam int WORD_W = 32;
   localparam int EN_W = 17;
   localparam logic [3:0] BLK_ALL = 4'hF;
   localparam logic [3:0] BLK_ONE = 4'h1;
   // Flag order: ready, rx end, tx end, rx full, tx empty, violation, tag
   localparam int NFLAGS = 7;
   localparam int F_RDY = 0;
   localparam int F_RECEIVE_COUNT_DONE = 1;
   localparam int F_TRANSMIT_COUNT_DONE = 2;
   localparam int F_RECEIVE_COUNTERS_ZERO = 3;
   localparam int F_TRANSMIT_COUNTERS_ZERO = 4;
   localparam int F_ACCESS_VIOLATION_SEEN = 5;
   localparam int F_TAG = 6;
   localparam int STAT_POS [NFLAGS] = '{0, 1, 2, 3, 4, 8, 16};
   localparam int ACCESS_VIOLATION_TYPE_LSB = 12;
   localparam int ACCESS_VIOLATION_TYPE_W = 4;
   localparam logic [3:0] VT_IN_WR = 4'h0;
   localparam logic [3:0] VT_OUT_RD = 4'h1;
   localparam logic [3:0] VT_MR_WR = 4'h2;
   localparam logic [3:0] VT_OUT_SUBK = 4'h3;
   localparam logic [3:0] VT_MR_SUBK = 4'h4;
   localparam logic [3:0] VT_WO_RD = 4'h5;
   localparam logic [3:0] VT_NONE = 4'h0;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {
      START_MANUAL = 2'h0,
      START_AUTO = 2'h1,
      START_DMA = 2'h2
   } start_sel_t;
   typedef enum logic [2:0] {
      MODE_ECB = 3'h0,
      MODE_CBC = 3'h1,
      MODE_OFB = 3'h2,
      MODE_CFB = 3'h3,
      MODE_CTR = 3'h4,
      MODE_GCM = 3'h5
   } chain_mode_t;

   function automatic logic hit(input logic [31:0] a,
                                input logic [31:0] base, input int n);
      return (a[1:0] == 2'h0) && (a >= base) && (a < base + 32'(4 * n));
   endfunction

   function automatic logic [IDX_W-1:0] widx(input logic [31:0] a,
                                             input logic [31:0] base);
      logic [31:0] d;
      d = a - base;
      return d[IDX_W+1:2];
   endfunction
endpackage

// ==== verilog/flag_cell.sv ====
// Sticky status flag where a set wins over a clear
`timescale 1ns/10ps
module flag_cell (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   logic q_reg;
   logic q_next;

   always_comb begin
      q_next = set | (q_reg & ~clr);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q_reg <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule

// ==== verilog/word_bank.sv ====
// Bank of write-only 32-bit words, flattened word 0 lowest
`timescale 1ns/10ps
module word_bank import aes_regs_pkg::*; #(
   parameter int N = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [WORD_W-1:0] wr_data,
   output logic [N*WORD_W-1:0] words
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_word
         logic [WORD_W-1:0] w_reg;
         logic [WORD_W-1:0] w_next;
         always_comb begin
            w_next = (wr_en && wr_idx == IDX_W'(i)) ? wr_data : w_reg;
         end
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               w_reg <= ZERO_WORD;
            end else begin
               w_reg <= w_next;
            end
         end
         assign words[i*WORD_W +: WORD_W] = w_reg;
      end
   endgenerate
endmodule

// ==== verilog/aes_status_key_data_regs.sv ====
// Status, mask, key, input, output and vector registers of the cipher
`timescale 1ns/10ps
// Behaviour
// - Mask view is read-only: enabled sources at bits 0-4, 8 and 16.
// - Ready sets on completion; clears on start, soft reset, output read.
// - Last-output mode, manual or auto start: input write clears ready.
// - Receive-end sets at receive count zero; counter write clears it.
// - Transmit-end sets at transmit count zero; counter write clears it.
// - Receive-full high only while both receive counters are zero.
// - Transmit-empty high only while both transmit counters are zero.
// - Violation flag sets on bad access, held until soft reset.
// - Violation type in bits 15:12 encodes codes 0 to 5.
// - Violation type keeps the latest code; soft reset clears it.
// - Tag flag sets on tag done; clears on tag read, start, key.
// - Eight key words, four, six or eight used, word 0 first.
// - Key write starts subkey generation and clears the hash.
// - Key words are write-only and never read back.
// - Four write-only input words, word 0 first, word 3 last.
// - Four read-only output words, word 0 first, word 3 last.
// - Four write-only vector words feed CBC, OFB and CFB chaining.
// - In counter mode the vector words are the initial counter.
// - Start select: 0 manual, 1 after all inputs, 2 on word 0.
// - Last-output mode lets input writes clear ready between blocks.
// - Chaining mode: ECB, CBC, OFB, CFB, counter, GCM; rest reserved.
module aes_status_key_data_regs import aes_regs_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [31:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire logic [EN_W-1:0] int_enable,
   input wire logic [1:0] start_select,
   input wire logic [2:0] chaining_mode,
   input wire logic last_output_mode,
   input wire logic start_cmd,
   input wire logic soft_reset_cmd,
   input wire logic mode_write,
   input wire logic core_busy,
   input wire logic subkey_busy,
   input wire logic core_done,
   input wire logic [BLK_WORDS*WORD_W-1:0] core_result,
   input wire logic tag_done,
   input wire logic tag_read,
   input wire logic rx_count_hit,
   input wire logic rx_counter_write,
   input wire logic rx_both_zero,
   input wire logic tx_count_hit,
   input wire logic tx_counter_write,
   input wire logic tx_both_zero,
   output logic irq,
   output logic [KEY_WORDS*WORD_W-1:0] key_word_value,
   output logic [BLK_WORDS*WORD_W-1:0] input_word_value,
   output logic [BLK_WORDS*WORD_W-1:0] init_vector,
   output logic run_start,
   output logic subkey_start,
   output logic hash_clear,
   output logic iv_as_chain,
   output logic iv_as_counter
);
   logic key_hit, in_hit, out_hit, iv_hit;
   logic [IDX_W-1:0] key_idx, in_idx, out_idx, iv_idx;
   logic key_wr, in_wr, iv_wr, out_rd, wo_rd;
   logic viol;
   logic [ACCESS_VIOLATION_TYPE_W-1:0] vtype;
   logic [ACCESS_VIOLATION_TYPE_W-1:0] access_violation_type_reg, access_violation_type_next;
   logic [NFLAGS-1:0] flag_q, set_v, clr_v;
   logic [3:0] in_seen_reg, in_seen_next;
   logic run_start_reg, run_start_next;
   logic subkey_start_reg, subkey_start_next;
   logic hash_clear_reg, hash_clear_next;
   logic iv_as_chain_reg, iv_as_chain_next;
   logic iv_as_counter_reg, iv_as_counter_next;
   logic [WORD_W-1:0] out_reg [BLK_WORDS];
   logic [WORD_W-1:0] out_next [BLK_WORDS];
   logic [31:0] rd_data_reg, rd_data_next;
   logic irq_reg, irq_next;
   logic [31:0] stat, imr;
   logic lod_clear, irq_cond;

   assign key_hit = hit(addr, KEY_BASE, KEY_WORDS);
   assign in_hit = hit(addr, IN_BASE, BLK_WORDS);
   assign out_hit = hit(addr, OUT_BASE, BLK_WORDS);
   assign iv_hit = hit(addr, IV_BASE, BLK_WORDS);
   assign key_idx = widx(addr, KEY_BASE);
   assign in_idx = widx(addr, IN_BASE);
   assign out_idx = widx(addr, OUT_BASE);
   assign iv_idx = widx(addr, IV_BASE);
   assign key_wr = wr_en & key_hit;
   assign in_wr = wr_en & in_hit;
   assign iv_wr = wr_en & iv_hit;
   assign out_rd = rd_en & out_hit;
   assign wo_rd = rd_en & (key_hit | in_hit | iv_hit);

   // Write-only banks
   word_bank #(.N(KEY_WORDS)) u_key (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(key_wr),
      .wr_idx(key_idx),
      .wr_data(wr_data),
      .words(key_word_value)
   );
   word_bank #(.N(BLK_WORDS)) u_in (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(in_wr),
      .wr_idx(in_idx),
      .wr_data(wr_data),
      .words(input_word_value)
   );
   word_bank #(.N(BLK_WORDS)) u_iv (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(iv_wr),
      .wr_idx(iv_idx),
      .wr_data(wr_data),
      .words(init_vector)
   );

   // Unspecified access detection, later checks take priority, subkey busy ahead of core busy
   always_comb begin
      viol = 1'b0;
      vtype = VT_NONE;
      if (wo_rd) begin
         viol = 1'b1;
         vtype = VT_WO_RD;
      end
      if (out_rd && subkey_busy) begin
         viol = 1'b1;
         vtype = VT_OUT_SUBK;
      end else if (out_rd && core_busy) begin
         viol = 1'b1;
         vtype = VT_OUT_RD;
      end
      if (mode_write && subkey_busy) begin
         viol = 1'b1;
         vtype = VT_MR_SUBK;
      end else if (mode_write && core_busy) begin
         viol = 1'b1;
         vtype = VT_MR_WR;
      end
      if (in_wr && core_busy && start_select == START_DMA) begin
         viol = 1'b1;
         vtype = VT_IN_WR;
      end
   end

   always_comb begin
      access_violation_type_next = access_violation_type_reg;
      if (viol) begin
         access_violation_type_next = vtype;
      end else if (soft_reset_cmd) begin
         access_violation_type_next = VT_NONE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         access_violation_type_reg <= VT_NONE;
      end else begin
         access_violation_type_reg <= access_violation_type_next;
      end
   end

   // Flag set and clear terms
   assign lod_clear = last_output_mode & in_wr &
                      (start_select != START_DMA);

   always_comb begin
      set_v = '0;
      clr_v = '0;
      set_v[F_RDY] = core_done;
      clr_v[F_RDY] = start_cmd | soft_reset_cmd | out_rd | lod_clear;
      set_v[F_RECEIVE_COUNT_DONE] = rx_count_hit;
      clr_v[F_RECEIVE_COUNT_DONE] = rx_counter_write | soft_reset_cmd;
      set_v[F_TRANSMIT_COUNT_DONE] = tx_count_hit;
      clr_v[F_TRANSMIT_COUNT_DONE] = tx_counter_write | soft_reset_cmd;
      set_v[F_RECEIVE_COUNTERS_ZERO] = rx_both_zero & ~rx_counter_write;
      clr_v[F_RECEIVE_COUNTERS_ZERO] = 1'b1;
      set_v[F_TRANSMIT_COUNTERS_ZERO] = tx_both_zero & ~tx_counter_write;
      clr_v[F_TRANSMIT_COUNTERS_ZERO] = 1'b1;
      set_v[F_ACCESS_VIOLATION_SEEN] = viol;
      clr_v[F_ACCESS_VIOLATION_SEEN] = soft_reset_cmd;
      set_v[F_TAG] = tag_done;
      clr_v[F_TAG] = tag_read | run_start_next | key_wr | soft_reset_cmd;
   end

   genvar f;
   generate
      for (f = 0; f < NFLAGS; f++) begin : g_flag
         flag_cell u_flag (
            .ref_clk(ref_clk),
            .rst(rst),
            .set(set_v[f]),
            .clr(clr_v[f]),
            .q(flag_q[f])
         );
      end
   endgenerate

   // Start control, key side effects and vector use
   always_comb begin
      in_seen_next = in_seen_reg;
      run_start_next = 1'b0;
      if (in_wr) begin
         in_seen_next = in_seen_reg | (BLK_ONE << in_idx);
      end
      unique case (start_select)
         START_AUTO: run_start_next = in_wr && in_seen_next == BLK_ALL;
         START_DMA: run_start_next = in_wr && in_idx == '0;
         default: run_start_next = start_cmd;
      endcase
      if (run_start_next || soft_reset_cmd) begin
         in_seen_next = '0;
      end
      subkey_start_next = key_wr;
      hash_clear_next = key_wr;
      iv_as_chain_next = chaining_mode == MODE_CBC ||
                         chaining_mode == MODE_OFB ||
                         chaining_mode == MODE_CFB;
      iv_as_counter_next = chaining_mode == MODE_CTR;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         in_seen_reg <= '0;
         run_start_reg <= 1'b0;
         subkey_start_reg <= 1'b0;
         hash_clear_reg <= 1'b0;
         iv_as_chain_reg <= 1'b0;
         iv_as_counter_reg <= 1'b0;
      end else begin
         in_seen_reg <= in_seen_next;
         run_start_reg <= run_start_next;
         subkey_start_reg <= subkey_start_next;
         hash_clear_reg <= hash_clear_next;
         iv_as_chain_reg <= iv_as_chain_next;
         iv_as_counter_reg <= iv_as_counter_next;
      end
   end

   // Result words captured on completion
   always_comb begin
      for (int i = 0; i < BLK_WORDS; i++) begin
         out_next[i] = core_done ? core_result[i*WORD_W +: WORD_W]
                                 : out_reg[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < BLK_WORDS; i++) begin
         if (rst) begin
            out_reg[i] <= ZERO_WORD;
         end else begin
            out_reg[i] <= out_next[i];
         end
      end
   end

   // Status and mask views
   always_comb begin
      stat = ZERO_WORD;
      imr = ZERO_WORD;
      for (int i = 0; i < NFLAGS; i++) begin
         stat[STAT_POS[i]] = flag_q[i];
         imr[STAT_POS[i]] = int_enable[STAT_POS[i]];
      end
      stat[ACCESS_VIOLATION_TYPE_LSB +: ACCESS_VIOLATION_TYPE_W] = access_violation_type_reg;
   end

   assign irq_cond = |(stat[EN_W-1:0] & imr[EN_W-1:0]);

   // Read data and interrupt
   always_comb begin
      rd_data_next = ZERO_WORD;
      if (rd_en) begin
         if (addr == IMR_ADDR) begin
            rd_data_next = imr;
         end else if (addr == ISR_ADDR) begin
            rd_data_next = stat;
         end else if (out_hit) begin
            rd_data_next = out_reg[out_idx[1:0]];
         end
      end
      irq_next = irq_cond;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data_reg <= ZERO_WORD;
         irq_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;
         irq_reg <= irq_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign irq = irq_reg;
   assign run_start = run_start_reg;
   assign subkey_start = subkey_start_reg;
   assign hash_clear = hash_clear_reg;
   assign iv_as_chain = iv_as_chain_reg;
   assign iv_as_counter = iv_as_counter_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_wo_read;
      rd_en && (key_hit || in_hit || iv_hit);
   endsequence
   sequence s_key_write;
      wr_en && key_hit;
   endsequence

   a_ready_set: assert property (
      core_done |=> flag_q[F_RDY]) else $error("ready not set");
   a_ready_clear: assert property (
      (start_cmd || out_rd) && !core_done |=> !flag_q[F_RDY])
      else $error("ready not cleared");
   a_lod_clear: assert property (
      lod_clear && !core_done |=> !flag_q[F_RDY])
      else $error("input write left ready set");
   a_rx_end: assert property (
      rx_count_hit |=> flag_q[F_RECEIVE_COUNT_DONE])
      else $error("rx end not set");
   a_tx_end: assert property (
      tx_counter_write && !tx_count_hit |=> !flag_q[F_TRANSMIT_COUNT_DONE])
      else $error("tx end not cleared");
   a_rx_full: assert property (
      rx_counter_write |=> !flag_q[F_RECEIVE_COUNTERS_ZERO]) else $error("rx full held");
   a_tx_empty: assert property (
      tx_both_zero && !tx_counter_write |=> flag_q[F_TRANSMIT_COUNTERS_ZERO])
      else $error("tx empty not set");
   a_viol_sticky: assert property (
      flag_q[F_ACCESS_VIOLATION_SEEN] && !soft_reset_cmd |=> flag_q[F_ACCESS_VIOLATION_SEEN])
      else $error("violation flag dropped");
   a_wo_read_zero: assert property (
      s_wo_read ##0 !mode_write |=> rd_data == ZERO_WORD &&
      access_violation_type_reg == VT_WO_RD && flag_q[F_ACCESS_VIOLATION_SEEN])
      else $error("write-only read leaked");
   a_key_kick: assert property (
      s_key_write ##0 !tag_done |=> subkey_start && hash_clear &&
      !flag_q[F_TAG]) else $error("key write side effects missing");
   a_dma_start: assert property (
      in_wr && in_idx == '0 && start_select == START_DMA |=> run_start)
      else $error("dma start missing");
   a_irq_follow: assert property (
      ##1 irq == $past(irq_cond)) else $error("interrupt mismatch");
endmodule

// ==== tb/core_model.sv ====
// Behavioural model of the cipher core and subkey engine
`timescale 1ns/10ps
module core_model import aes_regs_pkg::*; #(
   parameter int LAT = 24,
   parameter int SK_LAT = 24
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic run_start,
   input wire logic subkey_start,
   input wire logic [2:0] chaining_mode,
   input wire logic [BLK_WORDS*WORD_W-1:0] input_word_value,
   output logic core_busy,
   output logic subkey_busy,
   output logic core_done,
   output logic [BLK_WORDS*WORD_W-1:0] core_result,
   output logic tag_done
);
   int cnt;
   int sk;
   always_ff @(posedge ref_clk) begin
      core_done <= 1'b0;
      tag_done <= core_done && chaining_mode == MODE_GCM;
      // Result bus toggles outside the done pulse
      core_result <= ~core_result;
      if (rst) begin
         cnt <= 0;
         sk <= 0;
         core_busy <= 1'b0;
         subkey_busy <= 1'b0;
         tag_done <= 1'b0;
         core_result <= '0;
      end else begin
         if (run_start) begin
            cnt <= LAT;
            core_busy <= 1'b1;
         end else if (cnt == 1) begin
            cnt <= 0;
            core_busy <= 1'b0;
            core_done <= 1'b1;
            core_result <= ~input_word_value;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
         subkey_busy <= subkey_start || sk > 1;
         sk <= subkey_start ? SK_LAT : (sk > 0 ? sk - 1 : 0);
      end
   end
endmodule

// ==== tb/tb_aes_status_key_data_regs.sv ====
// Self-checking bench of the cipher status, key and data registers
`timescale 1ns/10ps
module tb_aes_status_key_data_regs import aes_regs_pkg::*;;
   localparam int P_START = 0;
   localparam int P_SRST = 1;
   localparam int P_MODE = 2;
   localparam int P_TAG = 3;
   localparam int P_RXH = 4;
   localparam int P_RXW = 5;
   localparam int P_TXH = 6;
   localparam int P_TXW = 7;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [31:0] addr = '0;
   logic [31:0] wr_data = '0;
   logic [31:0] rd_data;
   logic [31:0] d;
   logic wr_en = 1'h0, rd_en = 1'h0, last_output_mode = 1'h0;
   logic rx_both_zero = 1'h0, tx_both_zero = 1'h0;
   logic [7:0] pls = '0;
   logic [EN_W-1:0] int_enable = '0;
   logic [1:0] start_select = 2'h0;
   logic [2:0] chaining_mode = 3'h0;
   logic core_busy, subkey_busy, core_done, tag_done, irq;
   logic run_start, subkey_start, hash_clear, iv_as_chain, iv_as_counter;
   logic [BLK_WORDS*WORD_W-1:0] core_result, input_word_value, init_vector;
   logic [KEY_WORDS*WORD_W-1:0] key_word_value;
   logic [127:0] blk;
   int error_cnt = 0;
   int cmp_count = 0;

   aes_status_key_data_regs i_dut (.ref_clk(ref_clk), .rst(rst),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .int_enable(int_enable),
      .start_select(start_select), .chaining_mode(chaining_mode),
      .last_output_mode(last_output_mode), .start_cmd(pls[P_START]),
      .soft_reset_cmd(pls[P_SRST]), .mode_write(pls[P_MODE]),
      .core_busy(core_busy), .subkey_busy(subkey_busy),
      .core_done(core_done), .core_result(core_result),
      .tag_done(tag_done), .tag_read(pls[P_TAG]),
      .rx_count_hit(pls[P_RXH]), .rx_counter_write(pls[P_RXW]),
      .rx_both_zero(rx_both_zero), .tx_count_hit(pls[P_TXH]),
      .tx_counter_write(pls[P_TXW]), .tx_both_zero(tx_both_zero),
      .irq(irq), .key_word_value(key_word_value),
      .input_word_value(input_word_value), .init_vector(init_vector),
      .run_start(run_start), .subkey_start(subkey_start),
      .hash_clear(hash_clear), .iv_as_chain(iv_as_chain),
      .iv_as_counter(iv_as_counter));

   core_model i_core (.ref_clk(ref_clk), .rst(rst), .run_start(run_start),
      .subkey_start(subkey_start), .chaining_mode(chaining_mode),
      .input_word_value(input_word_value), .core_busy(core_busy),
      .subkey_busy(subkey_busy), .core_done(core_done),
      .core_result(core_result), .tag_done(tag_done));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'h1;
      @(posedge ref_clk);
      wr_en <= 1'h0;
      #1;
   endtask

   task automatic rd(input logic [31:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge ref_clk);
      rd_en <= 1'h0;
      #1;
      d = rd_data;
   endtask

   task automatic pulse(input int b);
      @(posedge ref_clk);
      pls[b] <= 1'h1;
      @(posedge ref_clk);
      pls <= '0;
   endtask

   task automatic stat(input logic [31:0] m, input logic [31:0] e);
      rd(ISR_ADDR);
      chk(d & m, e);
   endtask

   task automatic wait_bit(input int b);
      repeat (40) begin
         rd(ISR_ADDR);
         if (d[b] === 1'h1) break;
      end
      chk({31'h0, d[b]}, 32'h1);
   endtask

   task automatic test_done();
      $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      error_cnt++;
      $display("unexpected at %0t: run hung", $time);
      test_done();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'h0;
      int_enable <= 17'h1_FFFF;
      stat(32'hFFFF_FFFF, 32'h0);
      rd(IMR_ADDR);
      chk(d, 32'h0001_011F);
      int_enable <= 17'h0_0001;
      for (int i = 0; i < KEY_WORDS; i++) begin
         wr(KEY_BASE + 32'(4 * i), 32'hC0DE_0000 + 32'(i));
         chk({30'h0, subkey_start, hash_clear}, 32'h3);
      end
      for (int i = 0; i < KEY_WORDS; i++) begin
         chk(key_word_value[32*i +: 32], 32'hC0DE_0000 + 32'(i));
      end
      rd(KEY_BASE + 32'h4);
      chk(d, 32'h0);
      stat(32'h0000_F100, 32'h0000_5100);
      pulse(P_MODE);
      stat(32'h0000_F100, 32'h0000_4100);
      rd(OUT_BASE);
      stat(32'h0000_F100, 32'h0000_3100);
      pulse(P_SRST);
      stat(32'hFFFF_FFFF, 32'h0);
      wr(ISR_ADDR, 32'hFFFF_FFFF);
      rd(32'h4000_0100);
      chk(d, 32'h0);
      stat(32'hFFFF_FFFF, 32'h0);
      repeat (30) @(posedge ref_clk);
      // Auto start once all four input words are in
      start_select <= START_AUTO;
      for (int i = 0; i < BLK_WORDS; i++) begin
         blk[32*i +: 32] = 32'hDA7A_0000 + 32'(i);
         wr(IN_BASE + 32'(4 * i), blk[32*i +: 32]);
      end
      for (int i = 0; i < BLK_WORDS; i++) begin
         chk(input_word_value[32*i +: 32], blk[32*i +: 32]);
      end
      wait_bit(0);
      chk({31'h0, irq}, 32'h1);
      int_enable <= '0;
      repeat (3) @(posedge ref_clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      int_enable <= 17'h0_0001;
      for (int i = 0; i < BLK_WORDS; i++) begin
         rd(OUT_BASE + 32'(4 * i));
         chk(d, ~blk[32*i +: 32]);
      end
      stat(32'h0000_F101, 32'h0);
      start_select <= START_MANUAL;
      pulse(P_START);
      wait_bit(0);
      pulse(P_START);
      stat(32'h1, 32'h0);
      pulse(P_MODE);
      stat(32'h0000_F100, 32'h0000_2100);
      rd(OUT_BASE);
      stat(32'h0000_F100, 32'h0000_1100);
      wait_bit(0);
      last_output_mode <= 1'h1;
      wr(IN_BASE, 32'h0000_0055);
      stat(32'h1, 32'h0);
      last_output_mode <= 1'h0;
      start_select <= START_DMA;
      wr(IN_BASE, 32'h0000_0011);
      wr(IN_BASE, 32'h0000_0022);
      stat(32'h0000_F100, 32'h0000_0100);
      wait_bit(0);
      pulse(P_SRST);
      stat(32'hFFFF_FFFF, 32'h0);
      start_select <= START_MANUAL;
      chaining_mode <= MODE_GCM;
      pulse(P_START);
      wait_bit(16);
      pulse(P_TAG);
      stat(32'h0001_0000, 32'h0);
      pulse(P_START);
      wait_bit(16);
      wr(KEY_BASE, 32'h1234_5678);
      stat(32'h0001_0000, 32'h0);
      // Peripheral DMA flags, receive side with last-output mode off, transmit side with it on
      start_select <= START_DMA;
      pulse(P_RXH);
      stat(32'h2, 32'h2);
      pulse(P_RXW);
      stat(32'h2, 32'h0);
      rx_both_zero <= 1'h1;
      stat(32'h8, 32'h8);
      rx_both_zero <= 1'h0;
      stat(32'h8, 32'h0);
      last_output_mode <= 1'h1;
      pulse(P_TXH);
      stat(32'h4, 32'h4);
      pulse(P_TXW);
      stat(32'h4, 32'h0);
      tx_both_zero <= 1'h1;
      stat(32'h10, 32'h10);
      tx_both_zero <= 1'h0;
      stat(32'h10, 32'h0);
      chaining_mode <= MODE_CBC;
      for (int i = 0; i < BLK_WORDS; i++) begin
         wr(IV_BASE + 32'(4 * i), 32'h0F0F_0000 + 32'(i));
         chk(init_vector[32*i +: 32], 32'h0F0F_0000 + 32'(i));
      end
      rd(IV_BASE);
      chk(d, 32'h0);
      rd(IN_BASE);
      chk(d, 32'h0);
      for (int m = 0; m < 6; m++) begin
         chaining_mode <= 3'(m);
         repeat (3) @(posedge ref_clk);
         #1;
         chk({30'h0, iv_as_chain, iv_as_counter},
             (m >= 1 && m <= 3) ? 32'h2 : (m == 4 ? 32'h1 : 32'h0));
      end
      test_done();
   end
endmodule
